// file: common/cstx_regs.vh
// Constants for the core execution-control slice.
`ifndef CSTX_REGS_VH
`define CSTX_REGS_VH
// Processing states.
`define CSTX_ST_NORMAL 3'h0
`define CSTX_ST_STOPPED 3'h1
`define CSTX_ST_BACKGND 3'h2
`define CSTX_ST_EXCEPT 3'h3
`define CSTX_ST_HALTED 3'h4
// Operation codes on the operation port.
`define CSTX_OP_NONE 4'h0
`define CSTX_OP_TBL_SR 4'h1
`define CSTX_OP_TBL_SX 4'h2
`define CSTX_OP_TBL_UR 4'h3
`define CSTX_OP_TBL_UX 4'h4
`define CSTX_OP_LINK 4'h5
`define CSTX_OP_UNLINK 4'h6
`define CSTX_OP_NOP 4'h7
`define CSTX_OP_STOP 4'h8
`define CSTX_OP_LOW_POWER_HALT_INSTR 4'h9
`define CSTX_OP_OTHER 4'hA
// Operation sizes.
`define CSTX_SZ_BYTE 2'h0
`define CSTX_SZ_WORD 2'h1
`define CSTX_SZ_LONG 2'h2
// Operand register fields.
`define CSTX_OFS_HI 15
`define CSTX_OFS_LO 8
`define CSTX_FRAC_HI 7
`define CSTX_FRAC_LO 0
`define CSTX_FRAC_W 8
// Stack word step in bytes.
`define CSTX_STACK_STEP 32'h0000_0004
`define CSTX_ZERO32 32'h0000_0000
`endif

// file: core/cstx_interp.v
// Table interpolation datapath: lower entry plus fraction times difference over 256, with size and rounding.
`timescale 1ns/100ps
`default_nettype none
`include "cstx_regs.vh"
module cstx_interp (
  input wire mclk, // Clock.
  input wire rst_n, // Synchronised reset, active low.
  input wire ce, // Clock enable.
  input wire start, // Start one interpolation.
  input wire [3:0] op, // Table variant.
  input wire [1:0] size, // Byte, word or long.
  input wire [7:0] frac, // Interpolation fraction.
  input wire [31:0] y_lo, // Lower entry.
  input wire [31:0] y_hi, // Upper entry.
  output reg done_r, // Result valid pulse.
  output reg [31:0] res_r // Result.
);
  wire is_signed;
  wire is_round;
  wire signed [33:0] lo_x;
  wire signed [33:0] hi_x;
  wire signed [33:0] diff;
  wire signed [42:0] prod;
  wire signed [42:0] full;
  wire signed [42:0] ipart;
  wire [7:0] fpart;
  wire rnd_up;
  wire signed [42:0] rounded;
  wire [31:0] exact;
  wire [31:0] rres;
  function [33:0] ext;
    input [31:0] v;
    input [1:0] sz;
    input sg;
    begin
      if (sz == `CSTX_SZ_BYTE) begin
        ext = {{26{sg & v[7]}}, v[7:0]};
      end else if (sz == `CSTX_SZ_WORD) begin
        ext = {{18{sg & v[15]}}, v[15:0]};
      end else begin
        ext = {{2{sg & v[31]}}, v};
      end
    end
  endfunction
  function [31:0] fit;
    input [31:0] v;
    input [1:0] sz;
    begin
      if (sz == `CSTX_SZ_BYTE) begin
        fit = {24'h00_0000, v[7:0]};
      end else if (sz == `CSTX_SZ_WORD) begin
        fit = {16'h0000, v[15:0]};
      end else begin
        fit = v;
      end
    end
  endfunction
  assign is_signed = (op == `CSTX_OP_TBL_SR) || (op == `CSTX_OP_TBL_SX);
  assign is_round = (op == `CSTX_OP_TBL_SR) || (op == `CSTX_OP_TBL_UR);
  assign lo_x = ext(y_lo, size, is_signed);
  assign hi_x = ext(y_hi, size, is_signed);
  assign diff = hi_x - lo_x;
  assign prod = diff * $signed({1'b0, frac});
  assign full = (lo_x <<< `CSTX_FRAC_W) + prod;
  assign ipart = full >>> `CSTX_FRAC_W;
  assign fpart = full[7:0];
  // Round to nearest, ties to the even integer.
  assign rnd_up = fpart[7] & ((|fpart[6:0]) | ipart[0]);
  assign rounded = ipart + {42'h000_0000_0000, rnd_up};
  assign rres = fit(rounded[31:0], size);
  // Exact byte and word variants return the integer part shifted up with the fraction in the low byte; long returns the integer part only.
  assign exact = (size == `CSTX_SZ_LONG) ? full[39:8] : fit(full[31:0], (size == `CSTX_SZ_BYTE) ?
    `CSTX_SZ_WORD : `CSTX_SZ_LONG);
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      done_r <= 1'b0;
      res_r <= `CSTX_ZERO32;
    end else if (ce) begin
      done_r <= start;
      if (start) begin
        res_r <= is_round ? rres : exact;
      end
    end
  end
endmodule // cstx_interp
`default_nettype wire

// file: core/cstx_core.v
// Execution control: processing states, pipeline sync, frame link/unlink and table interpolation.
//
// Behaviour
// - Table offset is operand bits 15:8, fraction bits 7:0, result is lower entry plus fraction times difference over 256.
// - The signed rounded variant rounds to nearest with ties to even.
// - Four variants (signed/unsigned, rounded/exact) in byte, word and long, exact byte and word ones keep the fraction, exact long drops it.
// - The register-pair form interpolates between two register values using the destination fraction.
// - Frame link pushes the address register, loads it with the stack address and reserves a local area.
// - Frame unlink loads the stack pointer from the register and pops the saved value into it.
// - A no-operation waits until every earlier instruction has completed.
// - The core is always in exactly one of normal, background or exception state unless halted.
// - Either stop instruction enters a stopped form of normal state with no bus cycles.
// - Exception state makes no stacking or vector cycles, only enables fetch, and ends when the handler starts.
// - A bus or address error during exception processing halts the core.
// - Stopped resumes only on trace, interrupt or reset, and is distinct from halted.
`timescale 1ns/100ps
`default_nettype none
`include "cstx_regs.vh"
module cstx_core (
  input wire mclk, // Clock, 100 MHz.
  input wire nrst, // Asynchronous reset, active low.
  input wire ce, // Clock enable.
  input wire op_valid, // Operation offered.
  input wire [3:0] op, // Operation code.
  input wire [1:0] op_size, // Operation size.
  input wire op_pair, // Register-pair table form.
  input wire [31:0] interp_operand_register, // Offset and fraction operand.
  input wire [31:0] surface_fraction_register, // Fraction for the pair form.
  input wire [31:0] pair_lo, // First value of register pair.
  input wire [31:0] pair_hi, // Second value of register pair.
  input wire [31:0] table_base, // Table base address.
  input wire [31:0] addr_reg_in, // Address register operand value.
  input wire [31:0] frame_disp, // Signed frame displacement.
  input wire pipe_busy, // Earlier instructions still executing.
  input wire exc_req, // Exception request.
  input wire exc_trace, // Trace exception pending.
  input wire exc_irq, // Interrupt exception pending.
  input wire bkpt_req, // Enter background state.
  input wire bkpt_exit, // Leave background state.
  input wire handler_start, // First handler instruction starts.
  input wire bus_err, // Bus error.
  input wire addr_err, // Address error.
  input wire mem_ack, // Memory cycle done.
  input wire [31:0] mem_rdata, // Memory read data.
  output reg op_ready_r, // Operation completed pulse.
  output reg [2:0] proc_state_r, // Processing state.
  output reg fetch_en_r, // Instruction fetch allowed.
  output reg mem_req_r, // Memory request.
  output reg mem_we_r, // Memory write.
  output reg [31:0] mem_addr_r, // Memory address.
  output reg [31:0] mem_wdata_r, // Memory write data.
  output reg [31:0] stack_pointer, // Stack pointer.
  output reg [31:0] addr_reg_out_r, // Address register result.
  output reg addr_reg_we_r, // Address register write pulse.
  output reg [31:0] result_r, // Table result.
  output reg result_we_r // Table result valid pulse.
);
  localparam SQ_IDLE = 3'h0;
  localparam SQ_RD_LO = 3'h1;
  localparam SQ_RD_HI = 3'h2;
  localparam SQ_CALC = 3'h3;
  localparam SQ_LINK = 3'h4;
  localparam SQ_FRAME_UNLINK_INSTR = 3'h5;
  localparam SQ_WAIT = 3'h6;
  reg rs1_r;
  reg rst_n;
  reg [2:0] seq_r;
  reg [3:0] cur_op_r;
  reg [1:0] cur_sz_r;
  reg [7:0] frac_r;
  reg [31:0] lo_r;
  reg [31:0] hi_r;
  reg ip_start_r;
  wire ip_done;
  wire [31:0] ip_res;
  wire is_tbl;
  wire [31:0] ent_addr;
  wire [31:0] step;
  function [31:0] size_bytes;
    input [1:0] sz;
    begin
      if (sz == `CSTX_SZ_BYTE) begin
        size_bytes = 32'h0000_0001;
      end else if (sz == `CSTX_SZ_WORD) begin
        size_bytes = 32'h0000_0002;
      end else begin
        size_bytes = 32'h0000_0004;
      end
    end
  endfunction
  // ---------------------------------------------------------------
  // Reset release.
  // ---------------------------------------------------------------
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rs1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rst_n <= rs1_r;
    end
  end
  assign is_tbl = (op == `CSTX_OP_TBL_SR) || (op == `CSTX_OP_TBL_SX) || (op == `CSTX_OP_TBL_UR) ||
    (op == `CSTX_OP_TBL_UX);
  assign step = size_bytes(op_size);
  assign ent_addr = table_base + step * {24'h00_0000,
    interp_operand_register[`CSTX_OFS_HI:`CSTX_OFS_LO]};
  cstx_interp u_cstx_interp (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .start(ip_start_r),
    .op(cur_op_r),
    .size(cur_sz_r),
    .frac(frac_r),
    .y_lo(lo_r),
    .y_hi(hi_r),
    .done_r(ip_done),
    .res_r(ip_res)
  );
  // ---------------------------------------------------------------
  // Processing state and instruction sequencer.
  // ---------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      proc_state_r <= `CSTX_ST_NORMAL;
      seq_r <= SQ_IDLE;
      cur_op_r <= `CSTX_OP_NONE;
      cur_sz_r <= `CSTX_SZ_BYTE;
      frac_r <= 8'h00;
      lo_r <= `CSTX_ZERO32;
      hi_r <= `CSTX_ZERO32;
      ip_start_r <= 1'b0;
      op_ready_r <= 1'b0;
      fetch_en_r <= 1'b1;
      mem_req_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_addr_r <= `CSTX_ZERO32;
      mem_wdata_r <= `CSTX_ZERO32;
      stack_pointer <= `CSTX_ZERO32;
      addr_reg_out_r <= `CSTX_ZERO32;
      addr_reg_we_r <= 1'b0;
      result_r <= `CSTX_ZERO32;
      result_we_r <= 1'b0;
    end else if (ce) begin
      op_ready_r <= 1'b0;
      ip_start_r <= 1'b0;
      addr_reg_we_r <= 1'b0;
      result_we_r <= 1'b0;
      case (proc_state_r)
        `CSTX_ST_HALTED: begin
          fetch_en_r <= 1'b0;
          mem_req_r <= 1'b0;
        end
        `CSTX_ST_STOPPED: begin
          mem_req_r <= 1'b0;
          fetch_en_r <= 1'b0;
          if (exc_trace || exc_irq) begin
            proc_state_r <= `CSTX_ST_EXCEPT;
          end
        end
        `CSTX_ST_EXCEPT: begin
          fetch_en_r <= 1'b1;
          seq_r <= SQ_IDLE;
          if (bus_err || addr_err) begin
            proc_state_r <= `CSTX_ST_HALTED;
            fetch_en_r <= 1'b0;
            mem_req_r <= 1'b0;
          end else if (handler_start) begin
            proc_state_r <= `CSTX_ST_NORMAL;
          end
        end
        `CSTX_ST_BACKGND: begin
          fetch_en_r <= 1'b0;
          mem_req_r <= 1'b0;
          if (bkpt_exit) begin
            proc_state_r <= `CSTX_ST_NORMAL;
            fetch_en_r <= 1'b1;
          end
        end
        default: begin
          if (exc_req || bus_err || addr_err) begin
            proc_state_r <= `CSTX_ST_EXCEPT;
            mem_req_r <= 1'b0;
            seq_r <= SQ_IDLE;
          end else if (bkpt_req && seq_r == SQ_IDLE) begin
            proc_state_r <= `CSTX_ST_BACKGND;
          end else begin
            case (seq_r)
              SQ_IDLE: begin
                if (op_valid) begin
                  cur_op_r <= op;
                  cur_sz_r <= op_size;
                  if (op == `CSTX_OP_NOP) begin
                    seq_r <= SQ_WAIT;
                  end else if (op == `CSTX_OP_STOP || op == `CSTX_OP_LOW_POWER_HALT_INSTR) begin
                    op_ready_r <= 1'b1;
                    proc_state_r <= `CSTX_ST_STOPPED;
                    fetch_en_r <= 1'b0;
                  end else if (is_tbl && op_pair) begin
                    lo_r <= pair_lo;
                    hi_r <= pair_hi;
                    frac_r <= surface_fraction_register[`CSTX_FRAC_HI:`CSTX_FRAC_LO];
                    ip_start_r <= 1'b1;
                    seq_r <= SQ_CALC;
                  end else if (is_tbl) begin
                    frac_r <= interp_operand_register[`CSTX_FRAC_HI:`CSTX_FRAC_LO];
                    mem_req_r <= 1'b1;
                    mem_we_r <= 1'b0;
                    mem_addr_r <= ent_addr;
                    hi_r <= ent_addr + step;
                    seq_r <= SQ_RD_LO;
                  end else if (op == `CSTX_OP_LINK) begin
                    mem_req_r <= 1'b1;
                    mem_we_r <= 1'b1;
                    mem_addr_r <= stack_pointer - `CSTX_STACK_STEP;
                    mem_wdata_r <= addr_reg_in;
                    seq_r <= SQ_LINK;
                  end else if (op == `CSTX_OP_UNLINK) begin
                    stack_pointer <= addr_reg_in;
                    mem_req_r <= 1'b1;
                    mem_we_r <= 1'b0;
                    mem_addr_r <= addr_reg_in;
                    seq_r <= SQ_FRAME_UNLINK_INSTR;
                  end else begin
                    op_ready_r <= 1'b1;
                  end
                end
              end
              SQ_WAIT: begin
                if (!pipe_busy) begin
                  op_ready_r <= 1'b1;
                  seq_r <= SQ_IDLE;
                end
              end
              SQ_RD_LO: begin
                if (mem_ack) begin
                  lo_r <= mem_rdata;
                  mem_addr_r <= hi_r;
                  seq_r <= SQ_RD_HI;
                end
              end
              SQ_RD_HI: begin
                if (mem_ack) begin
                  hi_r <= mem_rdata;
                  mem_req_r <= 1'b0;
                  ip_start_r <= 1'b1;
                  seq_r <= SQ_CALC;
                end
              end
              SQ_CALC: begin
                if (ip_done) begin
                  result_r <= ip_res;
                  result_we_r <= 1'b1;
                  op_ready_r <= 1'b1;
                  seq_r <= SQ_IDLE;
                end
              end
              SQ_LINK: begin
                if (mem_ack) begin
                  mem_req_r <= 1'b0;
                  mem_we_r <= 1'b0;
                  addr_reg_out_r <= mem_addr_r;
                  addr_reg_we_r <= 1'b1;
                  stack_pointer <= mem_addr_r + frame_disp;
                  op_ready_r <= 1'b1;
                  seq_r <= SQ_IDLE;
                end
              end
              SQ_FRAME_UNLINK_INSTR: begin
                if (mem_ack) begin
                  mem_req_r <= 1'b0;
                  addr_reg_out_r <= mem_rdata;
                  addr_reg_we_r <= 1'b1;
                  stack_pointer <= stack_pointer + `CSTX_STACK_STEP;
                  op_ready_r <= 1'b1;
                  seq_r <= SQ_IDLE;
                end
              end
              default: begin
                seq_r <= SQ_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end
endmodule // cstx_core
`default_nettype wire

// file: tb/cstx_core_properties.sv
// Checker for the state, pipeline and frame behaviour of the core.
`timescale 1ns/100ps
`default_nettype none
`include "cstx_regs.vh"
module cstx_core_properties (
  input wire logic mclk, // Clock.
  input wire logic nrst, // Reset, active low.
  input wire logic ce, // Clock enable.
  input wire logic op_valid, // Operation offered.
  input wire logic [3:0] op, // Operation code.
  input wire logic pipe_busy, // Earlier work running.
  input wire logic exc_trace, // Trace wake.
  input wire logic exc_irq, // Interrupt wake.
  input wire logic handler_start, // Handler begins.
  input wire logic bus_err, // Bus error.
  input wire logic addr_err, // Address error.
  input wire logic op_ready_r, // Operation done.
  input wire logic [2:0] proc_state_r, // Processing state.
  input wire logic fetch_en_r, // Fetch allowed.
  input wire logic mem_req_r, // Memory request.
  input wire logic mem_we_r, // Memory write.
  input wire logic [31:0] mem_addr_r, // Memory address.
  input wire logic [31:0] stack_pointer, // Stack pointer.
  input wire logic result_we_r // Result valid.
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_state_legal; proc_state_r <= `CSTX_ST_HALTED; endproperty
  a_state_legal: assert property (p_state_legal) else $error("state code out of range");
  property p_halt_hold; proc_state_r == `CSTX_ST_HALTED |=> proc_state_r == `CSTX_ST_HALTED; endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halted state left without reset");
  property p_halt_quiet; proc_state_r == `CSTX_ST_HALTED |-> !fetch_en_r && !mem_req_r; endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("fetch or bus cycle while halted");
  property p_stop_quiet; proc_state_r == `CSTX_ST_STOPPED |-> !mem_req_r; endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("bus cycle while stopped");
  property p_stop_wake;
    proc_state_r == `CSTX_ST_STOPPED && !exc_trace && !exc_irq |=> proc_state_r == `CSTX_ST_STOPPED;
  endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("stopped left without wake event");
  property p_exc_halt;
    proc_state_r == `CSTX_ST_EXCEPT && ce && (bus_err || addr_err) |=> proc_state_r == `CSTX_ST_HALTED;
  endproperty
  a_exc_halt: assert property (p_exc_halt) else $error("error in exception state did not halt");
  property p_exc_end;
    proc_state_r == `CSTX_ST_EXCEPT && ce && handler_start && !bus_err && !addr_err
      |=> proc_state_r == `CSTX_ST_NORMAL;
  endproperty
  a_exc_end: assert property (p_exc_end) else $error("exception state did not end at handler start");
  property p_nop_wait; op_valid && op == `CSTX_OP_NOP && pipe_busy |=> !op_ready_r; endproperty
  a_nop_wait: assert property (p_nop_wait) else $error("no-operation finished while pipeline busy");
  property p_link_addr; mem_req_r && mem_we_r |-> mem_addr_r == stack_pointer - 32'h0000_0004; endproperty
  a_link_addr: assert property (p_link_addr) else $error("push address is not one word below stack");
  property p_tbl_ready; $rose(result_we_r) |-> op_ready_r; endproperty
  a_tbl_ready: assert property (p_tbl_ready) else $error("table result without completion");
  c_stopped: cover property (proc_state_r == `CSTX_ST_STOPPED);
  c_halted: cover property (proc_state_r == `CSTX_ST_HALTED);
  c_result: cover property (result_we_r);
endmodule // cstx_core_properties
bind cstx_core cstx_core_properties u_cstx_core_properties (.mclk, .nrst, .ce, .op_valid, .op, .pipe_busy,
  .exc_trace, .exc_irq, .handler_start, .bus_err, .addr_err, .op_ready_r, .proc_state_r, .fetch_en_r,
  .mem_req_r, .mem_we_r, .mem_addr_r, .stack_pointer, .result_we_r);
`default_nettype wire

// file: tb/cstx_mem_model.sv
// Behavioural memory answering the request port of the core.
`timescale 1ns/100ps
`default_nettype none
module cstx_mem_model (
  input wire logic mclk, // Clock.
  input wire logic slow, // Adds wait cycles before each answer.
  input wire logic mem_req, // Request.
  input wire logic mem_we, // Write.
  input wire logic [31:0] mem_addr, // Address.
  input wire logic [31:0] mem_wdata, // Write data.
  output logic mem_ack, // Answer pulse.
  output logic [31:0] mem_rdata // Read data.
);
  // Only the low address byte selects a cell, so scenarios keep their addresses apart in that byte.
  logic [31:0] mem [0:255];
  logic [1:0] wait_r;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0000_0000;
    wait_r = 2'h0;
    for (int i = 0; i < 256; i++) begin
      mem[i] = ~i;
    end
  end
  // Read data is inverted every cycle outside read answers so a stale capture is seen.
  always @(posedge mclk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      if (wait_r >= (slow ? 2'h3 : 2'h0)) begin
        mem_ack <= 1'b1;
        wait_r <= 2'h0;
        if (mem_we) begin
          mem[mem_addr[7:0]] <= mem_wdata;
        end else begin
          mem_rdata <= mem[mem_addr[7:0]];
        end
      end else begin
        wait_r <= wait_r + 2'h1;
      end
    end
  end
endmodule // cstx_mem_model
`default_nettype wire

// file: tb/cpu_state_and_table_exec_tb.sv
// Self-checking testbench for the core execution-control slice.
`timescale 1ns/100ps
`default_nettype none
`include "cstx_regs.vh"
module cpu_state_and_table_exec_tb;
  logic mclk = 1'b0, nrst = 1'b0, ce = 1'b1, op_valid = 1'b0, op_pair = 1'b0, pipe_busy = 1'b0, slow = 1'b0;
  logic exc_req = 1'b0, exc_trace = 1'b0, exc_irq = 1'b0, bkpt_req = 1'b0, bkpt_exit = 1'b0;
  logic handler_start = 1'b0, bus_err = 1'b0, addr_err = 1'b0;
  logic [3:0] op = 4'h0;
  logic [1:0] op_size = 2'h0;
  logic [31:0] interp_operand_register = 32'h0000_0000, surface_fraction_register = 32'h0000_0000;
  logic [31:0] pair_lo = 32'h0000_0000, pair_hi = 32'h0000_0000, table_base = 32'h0000_0000;
  logic [31:0] addr_reg_in = 32'h0000_0000, frame_disp = 32'h0000_0000;
  wire logic mem_ack, op_ready_r, fetch_en_r, mem_req_r, mem_we_r, addr_reg_we_r, result_we_r;
  wire logic [2:0] proc_state_r;
  wire logic [31:0] mem_rdata, mem_addr_r, mem_wdata_r, stack_pointer, addr_reg_out_r, result_r;
  int fail_count = 0;
  int tests_run = 0;
  logic [1:0] pulse_seen = 2'h0;
  always #5 mclk = ~mclk;
  cstx_core u_cstx_core (.mclk, .nrst, .ce, .op_valid, .op, .op_size, .op_pair, .interp_operand_register,
    .surface_fraction_register, .pair_lo, .pair_hi, .table_base, .addr_reg_in, .frame_disp, .pipe_busy,
    .exc_req, .exc_trace, .exc_irq, .bkpt_req, .bkpt_exit, .handler_start, .bus_err, .addr_err, .mem_ack,
    .mem_rdata, .op_ready_r, .proc_state_r, .fetch_en_r, .mem_req_r, .mem_we_r, .mem_addr_r, .mem_wdata_r,
    .stack_pointer, .addr_reg_out_r, .addr_reg_we_r, .result_r, .result_we_r);
  cstx_mem_model u_cstx_mem_model (.mclk(mclk), .slow(slow), .mem_req(mem_req_r), .mem_we(mem_we_r),
    .mem_addr(mem_addr_r), .mem_wdata(mem_wdata_r), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task final_report;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cst(input logic [2:0] exp);
    chk({29'h0000_0000, proc_state_r}, {29'h0000_0000, exp});
  endtask
  task step(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task do_reset;
    nrst = 1'b0;
    step(5);
    nrst = 1'b1;
    step(3);
  endtask
  // Offers one operation, waits for its completion pulse, then lets one cycle pass.
  task run(input logic [3:0] o, input logic [1:0] s, input logic p);
    int n;
    op = o;
    op_size = s;
    op_pair = p;
    op_valid = 1'b1;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (op_ready_r !== 1'b1 && n < 60);
    pulse_seen = {addr_reg_we_r, result_we_r};
    op_valid = 1'b0;
    chk({31'h0000_0000, op_ready_r}, 32'h0000_0001);
    step(1);
  endtask
  task t_pair(input logic [3:0] o, input logic [1:0] s, input logic [31:0] lo, input logic [31:0] hi,
              input logic [7:0] fr, input logic [31:0] exp, input logic [31:0] mask);
    pair_lo = lo;
    pair_hi = hi;
    surface_fraction_register = {24'h00_0000, fr};
    run(o, s, 1'b1);
    chk({30'h0000_0000, pulse_seen}, 32'h0000_0001);
    chk(result_r & mask, exp);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_link;
    addr_reg_in = 32'h1234_5678;
    frame_disp = 32'hFFFF_FFF8;
    run(`CSTX_OP_LINK, `CSTX_SZ_LONG, 1'b0);
    chk({30'h0000_0000, pulse_seen}, 32'h0000_0002);
    chk(addr_reg_out_r, 32'hFFFF_FFFC);
    chk(stack_pointer, 32'hFFFF_FFF4);
    chk(u_cstx_mem_model.mem[8'hFC], 32'h1234_5678);
    addr_reg_in = 32'hFFFF_FFFC;
    run(`CSTX_OP_UNLINK, `CSTX_SZ_LONG, 1'b0);
    chk({30'h0000_0000, pulse_seen}, 32'h0000_0002);
    chk(addr_reg_out_r, 32'h1234_5678);
    chk(stack_pointer, 32'h0000_0000);
  endtask
  task t_mem_table;
    table_base = 32'h0000_1000;
    interp_operand_register = 32'h0000_0BD0;
    slow = 1'b1;
    u_cstx_mem_model.mem[8'h16] = 32'h0000_0050;
    u_cstx_mem_model.mem[8'h18] = 32'h0000_0040;
    run(`CSTX_OP_TBL_SR, `CSTX_SZ_WORD, 1'b0);
    chk(result_r, 32'h0000_0043);
    run(`CSTX_OP_TBL_SX, `CSTX_SZ_WORD, 1'b0);
    chk(result_r, 32'h0000_4300);
    slow = 1'b0;
  endtask
  task t_nop;
    pipe_busy = 1'b1;
    op = `CSTX_OP_NOP;
    op_valid = 1'b1;
    repeat (8) begin
      step(1);
      chk({31'h0000_0000, op_ready_r}, 32'h0000_0000);
    end
    // With the clock enable low the finished wait must not complete.
    pipe_busy = 1'b0;
    ce = 1'b0;
    repeat (3) begin
      step(1);
      chk({31'h0000_0000, op_ready_r}, 32'h0000_0000);
    end
    ce = 1'b1;
    run(`CSTX_OP_NOP, `CSTX_SZ_BYTE, 1'b0);
  endtask
  task t_states;
    run(`CSTX_OP_STOP, `CSTX_SZ_BYTE, 1'b0);
    cst(`CSTX_ST_STOPPED);
    exc_req = 1'b1;
    step(3);
    exc_req = 1'b0;
    cst(`CSTX_ST_STOPPED);
    exc_irq = 1'b1;
    step(1);
    exc_irq = 1'b0;
    cst(`CSTX_ST_EXCEPT);
    bus_err = 1'b1;
    step(1);
    bus_err = 1'b0;
    cst(`CSTX_ST_HALTED);
    handler_start = 1'b1;
    exc_irq = 1'b1;
    step(2);
    handler_start = 1'b0;
    exc_irq = 1'b0;
    cst(`CSTX_ST_HALTED);
    chk({31'h0000_0000, fetch_en_r}, 32'h0000_0000);
    do_reset;
    cst(`CSTX_ST_NORMAL);
    run(`CSTX_OP_LOW_POWER_HALT_INSTR, `CSTX_SZ_BYTE, 1'b0);
    cst(`CSTX_ST_STOPPED);
    exc_trace = 1'b1;
    step(1);
    exc_trace = 1'b0;
    cst(`CSTX_ST_EXCEPT);
    handler_start = 1'b1;
    step(1);
    handler_start = 1'b0;
    cst(`CSTX_ST_NORMAL);
    bkpt_req = 1'b1;
    step(1);
    bkpt_req = 1'b0;
    cst(`CSTX_ST_BACKGND);
    bkpt_exit = 1'b1;
    step(1);
    bkpt_exit = 1'b0;
    cst(`CSTX_ST_NORMAL);
    exc_req = 1'b1;
    step(1);
    exc_req = 1'b0;
    cst(`CSTX_ST_EXCEPT);
    addr_err = 1'b1;
    step(1);
    addr_err = 1'b0;
    cst(`CSTX_ST_HALTED);
  endtask
  initial begin
    #100000;
    fail_count++;
    final_report;
  end
  initial begin
    do_reset;
    t_link;
    t_mem_table;
    t_pair(`CSTX_OP_TBL_SR, `CSTX_SZ_WORD, 32'h0000_0000, 32'h0000_0001, 8'h80, 32'h0000_0000, 32'hFFFF_FFFF);
    t_pair(`CSTX_OP_TBL_SR, `CSTX_SZ_WORD, 32'h0000_0001, 32'h0000_0002, 8'h80, 32'h0000_0002, 32'hFFFF_FFFF);
    t_pair(`CSTX_OP_TBL_UX, `CSTX_SZ_BYTE, 32'h0000_0010, 32'h0000_0020, 8'h40, 32'h0000_1400, 32'h0000_FFFF);
    t_pair(`CSTX_OP_TBL_SX, `CSTX_SZ_BYTE, 32'hFFFF_FFF0, 32'h0000_0010, 8'h40, 32'h0000_F800, 32'h0000_FFFF);
    t_pair(`CSTX_OP_TBL_UR, `CSTX_SZ_LONG, 32'h0000_0064, 32'h0000_00C8, 8'hC0, 32'h0000_00AF, 32'hFFFF_FFFF);
    t_pair(`CSTX_OP_TBL_SR, `CSTX_SZ_WORD, 32'h0000_4300, 32'h0000_4400, 8'h80, 32'h0000_4380, 32'hFFFF_FFFF);
    t_nop;
    t_states;
    final_report;
  end
endmodule // cpu_state_and_table_exec_tb
`default_nettype wire
